/* File: bcp_consts.vh */
/*
  Constants for the six-step commutation and protection block.
  Assumes a single 125 MHz system clock; hall and control pins may be asynchronous.
*/
`ifndef BCP_CONSTS_VH
`define BCP_CONSTS_VH

// Drive output levels
`define BCP_HI_OFF      1'h1
`define BCP_LO_OFF      1'h0

// Positions of the hall code bits {a,b,c}
`define BCP_HALL_A      2
`define BCP_HALL_B      1
`define BCP_HALL_C      0

// Phase one-hot indices
`define BCP_PH_A        3'h4
`define BCP_PH_B        3'h2
`define BCP_PH_C        3'h1
`define BCP_PH_NONE     3'h0

// Reset values of the output registers
`define BCP_HI_RST      3'h7
`define BCP_LO_RST      3'h0

// Latch levels, also their reset value
`define BCP_LATCH_SET   1'h1
`define BCP_LATCH_CLR   1'h0

`endif

/* File: bcp_commutation.v */
/*
  Six-step commutation decoder with dual-latch PWM and protection gating.
  Assumes the hall, direction, phasing and enable pins are asynchronous
  and synchronises them here; the analog comparators and oscillator sit
  outside and deliver single-bit indications already on clk_in.
*/
`timescale 1ns/10ps
`include "bcp_consts.vh"

// Contract
// - Phasing select high means 60 degree decode
// - Forward codes map to fixed high/low pairs
// - Reverse direction swaps high and low phases
// - High-side outputs active low, low-side high
// - Invalid sensor code turns all drives off
// - Enable low turns all drives off
// - Current sense high turns all drives off
// - Overcurrent holds drive off rest of cycle
// - Overcurrent resets the current-limit latch
// - At most one conduction pulse per cycle
// - Cycle start sets both latches
// - PWM latch gates only low-side outputs
// - Any undervoltage flag forces drives off
// - Over-temperature shuts all drives off
module bcp_commutation
(
  // Clock and reset
  input  wire clk_in,
  input  wire sys_rst_in,
  // Hall sensors
  input  wire hall_input_a_in,
  input  wire hall_input_b_in,
  input  wire hall_input_c_in,
  // Control
  input  wire phasing_60_in,
  input  wire dir_fwd_in,
  input  wire enable_in,
  // Oscillator and comparators
  input  wire cycle_start_in,
  input  wire ramp_above_cmd_in,
  input  wire current_sense_in,
  // Protection flags
  input  wire supply_uv_in,
  input  wire ref_uv_in,
  input  wire over_temp_in,
  // High-side drives, active low
  output reg  phase_a_high_drive_n_out,
  output reg  phase_b_high_drive_n_out,
  output reg  phase_c_high_drive_n_out,
  // Low-side drives, active high
  output reg  phase_a_low_drive_out,
  output reg  phase_b_low_drive_out,
  output reg  phase_c_low_drive_out,
  // Latch status
  output reg  pwm_latch_out,
  output reg  ilim_latch_out
);

  // Pin synchronisers: hall a,b,c, phasing, direction, enable
  reg  [5:0] pin_meta_r;
  reg  [5:0] pin_sync_r;
  wire [5:0] pin_raw;
  wire       sel60_s;
  wire       fwd_s;
  wire       en_s;

  // Per-mode decode results, one-hot phase as {A,B,C}
  reg  [2:0] hi60_sel;
  reg  [2:0] lo60_sel;
  reg        ok60;
  reg  [2:0] hi120_sel;
  reg  [2:0] lo120_sel;
  reg        ok120;
  wire [2:0] hall_code;
  wire [2:0] hi_sel;
  wire [2:0] lo_sel;
  wire       code_ok;
  wire [2:0] hi_ph;
  wire [2:0] lo_ph;

  // Protection gating and the two latches
  wire       uv_any;
  wire       fault;
  wire       gate_all;
  reg        pwm_latch_r;
  reg        pwm_latch_nxt;
  reg        ilim_latch_r;
  reg        ilim_latch_nxt;
  reg  [2:0] hi_drv_nxt;
  reg  [2:0] lo_drv_nxt;

  // Pins gathered so one pair of stages covers them all
  assign pin_raw = {hall_input_a_in, hall_input_b_in, hall_input_c_in,
                    phasing_60_in, dir_fwd_in, enable_in};

  // Two stages with no reset, so pins stay tracked through a reset.
  // Only the second stage is read; the first may go metastable.
  // Hall codes step one bit at a time, so bits crossing apart still
  // give the old code or the new one, never a third.
  always @(posedge clk_in)
  begin
    pin_meta_r <= pin_raw;
    pin_sync_r <= pin_meta_r;
  end

  // Settled pin values under their own names
  assign hall_code = pin_sync_r[5:3];
  assign sel60_s   = pin_sync_r[2];
  assign fwd_s     = pin_sync_r[1];
  assign en_s      = pin_sync_r[0];

  // 60 degree table, pairs given as high phase / low phase
  // Codes listed in rotor order for forward rotation
  always @*
  begin
    hi60_sel = `BCP_PH_NONE;
    lo60_sel = `BCP_PH_NONE;
    ok60     = 1'h1;
    case (hall_code)
      // Code 100: A high, C low
      3'h4:
      begin
        hi60_sel = `BCP_PH_A;
        lo60_sel = `BCP_PH_C;
      end
      // Code 110: B high, C low
      3'h6:
      begin
        hi60_sel = `BCP_PH_B;
        lo60_sel = `BCP_PH_C;
      end
      // Code 111: B high, A low
      3'h7:
      begin
        hi60_sel = `BCP_PH_B;
        lo60_sel = `BCP_PH_A;
      end
      // Code 011: C high, A low
      3'h3:
      begin
        hi60_sel = `BCP_PH_C;
        lo60_sel = `BCP_PH_A;
      end
      // Code 001: C high, B low
      3'h1:
      begin
        hi60_sel = `BCP_PH_C;
        lo60_sel = `BCP_PH_B;
      end
      // Code 000: A high, B low
      3'h0:
      begin
        hi60_sel = `BCP_PH_A;
        lo60_sel = `BCP_PH_B;
      end
      // Open or shorted sensor line
      3'h5: ok60 = 1'h0;
      3'h2: ok60 = 1'h0;
      default: ok60 = 1'h0;
    endcase
  end

  // 120 degree table, same pairs as the 60 degree one
  // Only the third and sixth codes differ between the two
  always @*
  begin
    hi120_sel = `BCP_PH_NONE;
    lo120_sel = `BCP_PH_NONE;
    ok120     = 1'h1;
    case (hall_code)
      // Code 100: A high, C low
      3'h4:
      begin
        hi120_sel = `BCP_PH_A;
        lo120_sel = `BCP_PH_C;
      end
      // Code 110: B high, C low
      3'h6:
      begin
        hi120_sel = `BCP_PH_B;
        lo120_sel = `BCP_PH_C;
      end
      // Code 010: B high, A low
      3'h2:
      begin
        hi120_sel = `BCP_PH_B;
        lo120_sel = `BCP_PH_A;
      end
      // Code 011: C high, A low
      3'h3:
      begin
        hi120_sel = `BCP_PH_C;
        lo120_sel = `BCP_PH_A;
      end
      // Code 001: C high, B low
      3'h1:
      begin
        hi120_sel = `BCP_PH_C;
        lo120_sel = `BCP_PH_B;
      end
      // Code 101: A high, B low
      3'h5:
      begin
        hi120_sel = `BCP_PH_A;
        lo120_sel = `BCP_PH_B;
      end
      // Open or shorted sensor line
      3'h7: ok120 = 1'h0;
      3'h0: ok120 = 1'h0;
      default: ok120 = 1'h0;
    endcase
  end

  // Both tables run every cycle; the select only picks one.
  // Selecting late keeps each table a plain constant case.
  assign hi_sel  = sel60_s ? hi60_sel : hi120_sel;
  assign lo_sel  = sel60_s ? lo60_sel : lo120_sel;
  assign code_ok = sel60_s ? ok60 : ok120;

  // Reverse simply exchanges which phase goes high and which goes low.
  // Invalid codes stay invalid in either direction.
  assign hi_ph = fwd_s ? hi_sel : lo_sel;
  assign lo_ph = fwd_s ? lo_sel : hi_sel;

  // Any protection condition blocks both sides outright.
  // Undervoltage and over-temperature act alike: all switches off.
  assign uv_any   = supply_uv_in | ref_uv_in;
  assign fault    = uv_any | over_temp_in;
  assign gate_all = en_s & code_ok & ~fault;

  // Dual latch: cycle start sets, comparators reset. Reset wins over a
  // simultaneous set so a sense pulse at cycle start is never missed.
  always @*
  begin
    pwm_latch_nxt  = pwm_latch_r;
    ilim_latch_nxt = ilim_latch_r;
    // Oscillator cycle start re-arms both latches
    if (cycle_start_in)
    begin
      pwm_latch_nxt  = `BCP_LATCH_SET;
      ilim_latch_nxt = `BCP_LATCH_SET;
    end
    // Comparator resets come after the set so they dominate
    if (ramp_above_cmd_in)
      pwm_latch_nxt = `BCP_LATCH_CLR;
    if (current_sense_in)
      ilim_latch_nxt = `BCP_LATCH_CLR;
  end

  // Current sense also kills drive in the same cycle, not one later
  always @*
  begin
    hi_drv_nxt = `BCP_HI_RST;
    lo_drv_nxt = `BCP_LO_RST;
    // Drive only with enable, a valid code, no fault, latch set
    if (gate_all && !current_sense_in && ilim_latch_nxt)
    begin
      hi_drv_nxt = ~hi_ph;
      // PWM chops the low side only, the high side stays on
      if (pwm_latch_nxt)
        lo_drv_nxt = lo_ph;
    end
  end

  // Latch state and its status copies; reset waits for a cycle start
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      pwm_latch_r    <= `BCP_LATCH_CLR;
      ilim_latch_r   <= `BCP_LATCH_CLR;
      pwm_latch_out  <= `BCP_LATCH_CLR;
      ilim_latch_out <= `BCP_LATCH_CLR;
    end
    else
    begin
      pwm_latch_r    <= pwm_latch_nxt;
      ilim_latch_r   <= ilim_latch_nxt;
      pwm_latch_out  <= pwm_latch_nxt;
      ilim_latch_out <= ilim_latch_nxt;
    end
  end

  // Registered drives; reset leaves every switch off
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      // High side off is a 1
      phase_a_high_drive_n_out <= `BCP_HI_OFF;
      phase_b_high_drive_n_out <= `BCP_HI_OFF;
      phase_c_high_drive_n_out <= `BCP_HI_OFF;
      // Low side off is a 0
      phase_a_low_drive_out    <= `BCP_LO_OFF;
      phase_b_low_drive_out    <= `BCP_LO_OFF;
      phase_c_low_drive_out    <= `BCP_LO_OFF;
    end
    else
    begin
      // High side, low-true one-hot
      phase_a_high_drive_n_out <= hi_drv_nxt[`BCP_HALL_A];
      phase_b_high_drive_n_out <= hi_drv_nxt[`BCP_HALL_B];
      phase_c_high_drive_n_out <= hi_drv_nxt[`BCP_HALL_C];
      // Low side, high-true one-hot
      phase_a_low_drive_out    <= lo_drv_nxt[`BCP_HALL_A];
      phase_b_low_drive_out    <= lo_drv_nxt[`BCP_HALL_B];
      phase_c_low_drive_out    <= lo_drv_nxt[`BCP_HALL_C];
    end
  end

endmodule

/* File: bcp_hall_model.sv */
/* Hall sensor model: six rotor steps plus two broken-wire codes.
   Assumes the step input changes just after a clock edge. */
`timescale 1ns/10ps
module bcp_hall_model
(
  // Rotor step, 6 and 7 mimic faulty wiring
  input  wire [2:0] step_in,
  input  wire       sel60_in,
  // Sensor code {a,b,c}
  output reg  [2:0] code_out
);
  // Codes in rotor order for the chosen phasing
  always @*
  begin
    case (step_in)
      3'h0: code_out = 3'h4;
      3'h1: code_out = 3'h6;
      3'h2: code_out = sel60_in ? 3'h7 : 3'h2;
      3'h3: code_out = 3'h3;
      3'h4: code_out = 3'h1;
      3'h5: code_out = sel60_in ? 3'h0 : 3'h5;
      3'h6: code_out = sel60_in ? 3'h5 : 3'h7;
      default: code_out = sel60_in ? 3'h2 : 3'h0;
    endcase
  end
endmodule

/* File: bcp_commutation_props.sv */
/* Port assertions for the commutation block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module bcp_commutation_props
(
  // Clock, reset and inputs
  input wire clk_in, sys_rst_in, phasing_60_in, dir_fwd_in, enable_in,
  input wire hall_input_a_in, hall_input_b_in, hall_input_c_in,
  input wire cycle_start_in, ramp_above_cmd_in, current_sense_in,
  input wire supply_uv_in, ref_uv_in, over_temp_in,
  // Drives and latch status
  input wire phase_a_high_drive_n_out, phase_b_high_drive_n_out,
  input wire phase_c_high_drive_n_out, phase_a_low_drive_out,
  input wire phase_b_low_drive_out, phase_c_low_drive_out,
  input wire pwm_latch_out, ilim_latch_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Comparator and flag inputs answer after one edge; the synchronised
  // pins (hall, phasing, direction, enable) after three
  wire [2:0] hi_w = {phase_a_high_drive_n_out, phase_b_high_drive_n_out,
    phase_c_high_drive_n_out};
  wire [2:0] lo_w = {phase_a_low_drive_out, phase_b_low_drive_out,
    phase_c_low_drive_out};
  wire [2:0] hc_w = {hall_input_a_in, hall_input_b_in, hall_input_c_in};
  wire off_w = hi_w == 3'h7 && lo_w == 3'h0;
  en_off_a: assert property (!enable_in |-> ##3 off_w)
    else $error("drive on while disabled");
  sense_off_a: assert property (current_sense_in |=>
    off_w && !ilim_latch_out) else $error("drive on during overcurrent");
  fault_off_a: assert property (supply_uv_in || ref_uv_in ||
    over_temp_in |=> off_w) else $error("drive on during fault");
  bad_code_a: assert property ((phasing_60_in ?
    hc_w == 3'h5 || hc_w == 3'h2 : hc_w == 3'h7 || hc_w == 3'h0)
    |-> ##3 off_w) else $error("drive on for invalid code");
  limit_hold_a: assert property (!ilim_latch_out &&
    !cycle_start_in |=> !ilim_latch_out && off_w)
    else $error("limit latch released early");
  start_set_a: assert property (cycle_start_in &&
    !current_sense_in && !ramp_above_cmd_in |=> pwm_latch_out &&
    ilim_latch_out) else $error("cycle start did not set latches");
  ramp_clr_a: assert property (ramp_above_cmd_in |=>
    !pwm_latch_out && lo_w == 3'h0) else $error("low drive past ramp");
  fwd_pair_a: assert property (dir_fwd_in && hc_w == 3'h4 |-> ##3
    hi_w inside {3'h3, 3'h7} && lo_w inside {3'h1, 3'h0})
    else $error("wrong forward pair");
  rev_pair_a: assert property (!dir_fwd_in && hc_w == 3'h4 |-> ##3
    hi_w inside {3'h6, 3'h7} && lo_w inside {3'h4, 3'h0})
    else $error("wrong reverse pair");
endmodule

/* File: bcp_commutation_tb.sv */
/* Random bench with a reference model and an expectation queue.
   Assumes the hall model and checker sit beside the block. */
`timescale 1ns/10ps
module bcp_commutation_tb;
  // Step 0..5 pairs, step 5 in the top slot
  localparam [17:0] HI_T = {3'h4, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4};
  localparam [17:0] LO_T = {3'h2, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1};
  reg clk_in = 1'h0;
  reg sys_rst_in = 1'h1;
  reg phasing_60_in, dir_fwd_in, enable_in, cycle_start_in;
  reg ramp_above_cmd_in, current_sense_in, supply_uv_in, ref_uv_in;
  reg over_temp_in, rs, ok, pwm_m, ilim_m;
  reg [2:0] step_r, k, kd, h, l;
  reg [5:0] pin_d1, pin_d2;
  reg [7:0] e;
  reg [7:0] exp_q[$];
  reg [31:0] seed = 32'he939;
  integer num_errors = 0, compares = 0, n;
  wire [2:0] code_w;
  wire hall_input_a_in = code_w[2];
  wire hall_input_b_in = code_w[1];
  wire hall_input_c_in = code_w[0];
  wire phase_a_high_drive_n_out, phase_b_high_drive_n_out;
  wire phase_c_high_drive_n_out, phase_a_low_drive_out;
  wire phase_b_low_drive_out, phase_c_low_drive_out;
  wire pwm_latch_out, ilim_latch_out;
  wire [7:0] got = {phase_a_high_drive_n_out, phase_b_high_drive_n_out,
    phase_c_high_drive_n_out, phase_a_low_drive_out, phase_b_low_drive_out,
    phase_c_low_drive_out, pwm_latch_out, ilim_latch_out};
  bcp_commutation bcp_commutation_i (.*);
  bcp_hall_model bcp_hall_model_i (.step_in(step_r),
    .sel60_in(phasing_60_in), .code_out(code_w));
  always #4 clk_in = ~clk_in;
  initial {phasing_60_in, dir_fwd_in, enable_in, cycle_start_in, step_r,
    ramp_above_cmd_in, current_sense_in, supply_uv_in, ref_uv_in,
    over_temp_in, pwm_m, ilim_m, pin_d1, pin_d2} = 26'h0;
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task print_verdict;
    begin
      if (num_errors == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Driver: random inputs, a mid-run reset, expected result queued
  initial
  begin
    for (n = 0; n < 3000; n = n + 1)
    begin
      @(posedge clk_in);
      seed = xs(seed);
      k = seed[2:0];
      rs = n < 6 || (n > 1500 && n < 1504);
      sys_rst_in <= rs;
      step_r <= k;
      phasing_60_in <= seed[3];
      dir_fwd_in <= seed[4];
      enable_in <= |seed[7:5];
      cycle_start_in <= seed[10:8] == 3'h0;
      ramp_above_cmd_in <= seed[13:11] == 3'h0;
      current_sense_in <= seed[16:14] == 3'h0;
      supply_uv_in <= seed[21:17] == 5'h0;
      ref_uv_in <= seed[26:22] == 5'h0;
      over_temp_in <= seed[31:27] == 5'h0;
      ilim_m = !rs && |seed[16:14] && (seed[10:8] == 3'h0 || ilim_m);
      pwm_m = !rs && |seed[13:11] && (seed[10:8] == 3'h0 || pwm_m);
      // Pins reach the decode through two sync stages, two draws late
      kd = pin_d2[5:3];
      ok = ilim_m && kd < 3'h6 && pin_d2[0] && |seed[21:17] &&
        |seed[26:22] && |seed[31:27];
      {h, l} = pin_d2[1] ? {HI_T[3*kd+:3], LO_T[3*kd+:3]} :
        {LO_T[3*kd+:3], HI_T[3*kd+:3]};
      exp_q.push_back({ok ? ~h : 3'h7, ok && pwm_m ? l : 3'h0, pwm_m,
        ilim_m});
      {pin_d2, pin_d1} = {pin_d1, k, seed[3], seed[4], |seed[7:5]};
    end
    print_verdict;
  end
  // Monitor: outputs settle one edge after the inputs they answer
  always @(negedge clk_in)
  begin
    if (exp_q.size() > 1)
    begin
      e = exp_q.pop_front();
      compares = compares + 1;
      if (got !== e)
      begin
        num_errors = num_errors + 1;
        $display("wrong value drives expected %h seen %h", e, got);
      end
    end
  end
  // Watchdog well past the 3000-cycle run
  initial
  begin
    #40000;
    num_errors = num_errors + 1;
    print_verdict;
  end
endmodule
bind bcp_commutation bcp_commutation_props bcp_commutation_props_i (.*);
